// file: rtl/mcs_params.svh
/*
  Constants for the microcode store access block: opcodes, store geometry,
  general register numbers and buffer depth.
  Assumes it is included by bare name after the package is compiled.
*/
// Overview of operation
// - 2048 fixed words at 000-7FF, 2048 writable words at 800-FFF.
// - every store word is 32 bits, one microinstruction.
// - store load (E80) takes memory start address from second register field.
// - store load base from register 0, count minus one from register 1.
// - load writes word to base plus count, count drops, ends at minus one.
// - interrupted load or read leaves location counter unadvanced for resumption.
// - store read (E82): store base reg 2, count reg 3, memory address from second register field.
// - store read decrements register 3 per word, ends at minus one.
// - reading fixed addresses below 800 delivers undefined data.
// - load, read and branch instructions are privileged.
// - branch (E5) jumps to low 12 bits of second operand address.
// - branch target is not checked; unpopulated targets are unpredictable.
// - on branch or entry, advanced and unadvanced counters go to microprogram.
// - entry (E9) jumps to 800 plus 4-bit first register field.
// - load and read keep condition code; branch and entry leave it to microcode.
// - branch field and entry index/immediate fields carry no hardware meaning.
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// ----------------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------------
`define MCS_OP_XFER 8'he8
`define MCS_SUB_LOAD 4'h0
`define MCS_SUB_READ 4'h2
`define MCS_OP_BRANCH 8'he5
`define MCS_OP_ENTRY 8'he9

// ----------------------------------------------------------------------------
// store geometry
// ----------------------------------------------------------------------------
`define MCS_WORD_W 32
`define MCS_UADDR_W 12
`define MCS_WR_WORDS 2048
`define MCS_WR_IDX_W 11
`define MCS_ENTRY_BASE 12'h800
`define MCS_MEM_ADDR_W 20

// ----------------------------------------------------------------------------
// general registers written back and buffering
// ----------------------------------------------------------------------------
`define MCS_GR_LOAD_CNT 2'h1
`define MCS_GR_READ_CNT 2'h3
`define MCS_FIFO_DEPTH 16

`endif

// file: rtl/mcs_pkg.sv
/*
  Types for the microcode store access block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mcs_pkg;

  // gray codes along idle -> run -> finish
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_FINISH = 2'b11
  } xfer_state_t;

  typedef enum logic {
    MODE_LOAD = 1'b0,
    MODE_READ = 1'b1
  } xfer_mode_t;

endpackage : mcs_pkg

// file: rtl/mcs_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a flush.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module mcs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk, // clock
  input wire logic reset_n, // sync reset, active low
  input wire logic flush, // drop all content
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // ----------------------------------------------------------------------------
  // status and head word
  // ----------------------------------------------------------------------------
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  // storage, no reset needed on the data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers wrap on a power-of-two depth
  always_ff @(posedge sys_clk) begin
    if (!reset_n || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : mcs_fifo

// file: rtl/microcode_store_access.sv
/*
  Writable microcode store with block load/read instructions, control-store
  branch and fast entry dispatch, plus microword fetch for the sequencer.
  Assumes the execution engine presents the current register set values,
  accepts count write-backs and honours the done/advance answer; main memory
  answers one request at a time with a one-cycle mem_ack.
*/
`timescale 1ns/1ps
`include "mcs_params.svh"
module microcode_store_access #(
  parameter int FIFO_DEPTH = `MCS_FIFO_DEPTH,
  parameter int WR_WORDS = `MCS_WR_WORDS
) (
  input wire logic sys_clk, // 125 MHz clock
  input wire logic reset_n, // sync reset, active low
  input wire logic instr_valid, // instruction offered
  output logic instr_ready, // instruction taken when valid
  input wire logic [7:0] instr_op, // opcode byte
  input wire logic [3:0] instr_r1, // first register field
  input wire logic [31:0] instr_addr2, // second operand address (branch)
  input wire logic prot_mode, // program state word protect bit
  input wire logic [31:0] gr_r2, // register named
  input wire logic [31:0] gr0, // general register 0
  input wire logic [31:0] gr1, // general register 1
  input wire logic [31:0] gr2, // general register 2
  input wire logic [31:0] gr3, // general register 3
  input wire logic [31:0] loc_cur, // unadvanced location counter
  input wire logic [31:0] loc_next, // advanced location counter
  input wire logic irq_pending, // interrupt waiting
  output logic priv_fault, // privileged op in protect mode
  output logic cnt_wr_valid, // count register write pulse
  output logic [1:0] cnt_wr_idx, // register 1 or 3
  output logic [31:0] cnt_wr_data, // new count value
  output logic xfer_done, // transfer ended pulse
  output logic loc_advance, // advance location counter on done
  output logic useq_jump, // microsequencer jump pulse
  output logic [11:0] useq_target, // jump microaddress
  output logic [31:0] useq_loc_cur, // unadvanced counter at entry
  output logic [31:0] useq_loc_next, // advanced counter at entry
  output logic cc_from_ucode, // condition code now set by microcode
  output logic mem_req, // memory request, held to ack
  output logic mem_we, // memory write
  output logic [19:0] mem_addr, // memory byte address
  output logic [31:0] mem_wdata, // memory write data
  input wire logic mem_ack, // memory done, one cycle
  input wire logic [31:0] mem_rdata, // memory read data
  input wire logic ucode_rd_en, // sequencer fetch
  input wire logic [11:0] ucode_addr, // sequencer microaddress
  output logic [10:0] rom_addr, // fixed store address
  input wire logic [31:0] rom_data, // fixed store word
  output logic [31:0] ucode_data // fetched microword
);

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // memory address for a given count; high words first keeps resume simple
  function automatic logic [19:0] word_addr(input logic [31:0] base, input logic [31:0] cnt);
    logic [31:0] sum;
    sum = base + {cnt[29:0], 2'b00};
    return sum[19:0];
  endfunction : word_addr

  // writable store index for base plus count
  function automatic logic [10:0] store_idx(input logic [31:0] base, input logic [31:0] cnt);
    logic [31:0] sum;
    sum = base + cnt;
    return sum[10:0];
  endfunction : store_idx

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  mcs_pkg::xfer_state_t state_q, state_d;
  mcs_pkg::xfer_mode_t mode_q;
  logic [31:0] ws_q [WR_WORDS];
  logic [31:0] r2_q, base_q, cnt_q, iss_q, rd_word_q, mem_wdata_q, cwd_q, lc_q, ln_q, ucode_q;
  logic iss_end_q, stop_q, pend_q, mem_req_q, mem_we_q, done_q, adv_q, cwv_q, fault_q, jump_q;
  logic [19:0] mem_addr_q;
  logic [1:0] cwi_q;
  logic [11:0] target_q;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
  logic [31:0] f_in_data, f_out_data;

  // ----------------------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------------------
  wire idle = (state_q == mcs_pkg::ST_IDLE);
  wire take = instr_valid && idle;
  wire is_xfer = (instr_op == `MCS_OP_XFER);
  wire is_load = is_xfer && (instr_r1 == `MCS_SUB_LOAD);
  wire is_read = is_xfer && (instr_r1 == `MCS_SUB_READ);
  wire is_branch = (instr_op == `MCS_OP_BRANCH);
  wire is_entry = (instr_op == `MCS_OP_ENTRY);
  wire is_priv = is_load || is_read || is_branch;
  wire blocked = is_priv && prot_mode;
  wire start_load = take && is_load && !blocked;
  wire start_read = take && is_read && !blocked;
  wire start_jump = take && (is_branch || is_entry) && !blocked;
  // low 12 bits of operand address, no
  // entry base plus other fields ignored
  wire [11:0] jump_to = is_branch ? instr_addr2[11:0] : (`MCS_ENTRY_BASE | {8'h00, instr_r1});

  assign instr_ready = idle;

  // ----------------------------------------------------------------------------
  // transfer engine conditions
  // ----------------------------------------------------------------------------
  wire running = (state_q == mcs_pkg::ST_RUN);
  wire load_m = (mode_q == mcs_pkg::MODE_LOAD);
  wire port_idle = !mem_req_q;
  // producer: memory read for load, store read for read
  wire can_issue = running && !stop_q && !iss_end_q && f_in_ready && port_idle;
  wire issue_load = can_issue && load_m;
  wire issue_read = can_issue && !load_m && !pend_q;
  // drain: store write for load, memory write for read
  wire drain_wr = running && !load_m && !stop_q && f_out_valid && port_idle;
  // a word counts only when it is fully placed
  wire commit = running && (load_m ? (f_out_valid && f_out_ready) : (mem_ack && mem_we_q));
  // ends when count passes zero to minus one
  wire last = commit && (cnt_q == 32'h0000_0000);
  // interrupt only between words, after the count update
  wire halt = commit && !last && irq_pending;
  wire quiet = port_idle && !pend_q;

  assign f_out_ready = load_m ? (running && !stop_q) : (mem_ack && mem_we_q);
  assign f_in_valid = load_m ? (running && mem_ack && !mem_we_q) : pend_q;
  assign f_in_data = load_m ? mem_rdata : rd_word_q;
  // stale prefetched words are dropped; they are refetched on resume
  assign f_flush = (state_q == mcs_pkg::ST_FINISH);

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      mcs_pkg::ST_IDLE: begin
        if (start_load || start_read) begin
          state_d = mcs_pkg::ST_RUN;
        end
      end
      mcs_pkg::ST_RUN: begin
        if ((last || stop_q) && quiet && !mem_req_q) begin
          state_d = mcs_pkg::ST_FINISH;
        end
      end
      mcs_pkg::ST_FINISH: begin
        state_d = mcs_pkg::ST_IDLE;
      end
      default: begin
        state_d = mcs_pkg::ST_IDLE;
      end
    endcase
  end

  // state and operands
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= mcs_pkg::ST_IDLE;
      mode_q <= mcs_pkg::MODE_LOAD;
      r2_q <= 32'h0000_0000;
      base_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (start_load || start_read) begin
        mode_q <= start_read ? mcs_pkg::MODE_READ : mcs_pkg::MODE_LOAD;
        r2_q <= gr_r2;
        base_q <= start_read ? gr2 : gr0;
      end
    end
  end

  // counts: issue runs ahead, committed count trails
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_q <= 32'h0000_0000;
      iss_q <= 32'h0000_0000;
      iss_end_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (start_load || start_read) begin
      // count from register 1 or 3
      cnt_q <= start_read ? gr3 : gr1;
      iss_q <= start_read ? gr3 : gr1;
      iss_end_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (issue_load || issue_read) begin
        iss_q <= iss_q - 32'h0000_0001;
        iss_end_q <= (iss_q == 32'h0000_0000);
      end
      if (commit) begin
        cnt_q <= cnt_q - 32'h0000_0001;
      end
      if (halt || last) begin
        stop_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // writable store
  // ----------------------------------------------------------------------------
  // 2048 x 32 writable words; written at base plus count
  always_ff @(posedge sys_clk) begin
    if (commit && load_m) begin
      ws_q[store_idx(base_q, cnt_q)] <= f_out_data;
    end
  end

  // addresses below 800 alias the writable array: undefined data
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
      rd_word_q <= 32'h0000_0000;
    end else begin
      pend_q <= issue_read;
      if (issue_read) begin
        rd_word_q <= ws_q[store_idx(base_q, iss_q)];
      end
    end
  end

  // sequencer fetch, fixed half from external read-only store
  assign rom_addr = ucode_addr[10:0];
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ucode_q <= 32'h0000_0000;
    end else if (ucode_rd_en) begin
      ucode_q <= ucode_addr[11] ? ws_q[ucode_addr[10:0]] : rom_data;
    end
  end
  assign ucode_data = ucode_q;

  // ----------------------------------------------------------------------------
  // main memory port
  // ----------------------------------------------------------------------------
  // caller aligns low bits pass through unchanged
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 20'h0_0000;
      mem_wdata_q <= 32'h0000_0000;
    end else if (mem_req_q) begin
      if (mem_ack) begin
        mem_req_q <= 1'b0;
      end
    end else if (issue_load) begin
      mem_req_q <= 1'b1;
      mem_we_q <= 1'b0;
      mem_addr_q <= word_addr(r2_q, iss_q);
    end else if (drain_wr) begin
      mem_req_q <= 1'b1;
      mem_we_q <= 1'b1;
      mem_addr_q <= word_addr(r2_q, cnt_q);
      mem_wdata_q <= f_out_data;
    end
  end
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;

  // ----------------------------------------------------------------------------
  // answers to the execution engine
  // ----------------------------------------------------------------------------
  // advance only if the count ran out; no condition code output
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      adv_q <= 1'b0;
      cwv_q <= 1'b0;
      cwi_q <= 2'h0;
      cwd_q <= 32'h0000_0000;
      fault_q <= 1'b0;
    end else begin
      done_q <= (state_q == mcs_pkg::ST_FINISH);
      if (last) begin
        adv_q <= 1'b1;
      end else if (start_load || start_read) begin
        adv_q <= 1'b0;
      end
      cwv_q <= commit;
      cwi_q <= load_m ? `MCS_GR_LOAD_CNT : `MCS_GR_READ_CNT;
      cwd_q <= cnt_q - 32'h0000_0001;
      fault_q <= take && blocked;
    end
  end
  assign xfer_done = done_q;
  assign loc_advance = adv_q && done_q;
  assign cnt_wr_valid = cwv_q;
  assign cnt_wr_idx = cwi_q;
  assign cnt_wr_data = cwd_q;
  assign priv_fault = fault_q;

  // both counter values handed over; microcode owns cc
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      jump_q <= 1'b0;
      target_q <= 12'h000;
      lc_q <= 32'h0000_0000;
      ln_q <= 32'h0000_0000;
    end else begin
      jump_q <= start_jump;
      if (start_jump) begin
        target_q <= jump_to;
        lc_q <= loc_cur;
        ln_q <= loc_next;
      end
    end
  end
  assign useq_jump = jump_q;
  assign cc_from_ucode = jump_q;
  assign useq_target = target_q;
  assign useq_loc_cur = lc_q;
  assign useq_loc_next = ln_q;

  // ----------------------------------------------------------------------------
  // data buffer
  // ----------------------------------------------------------------------------
  mcs_fifo #(
    .WIDTH(`MCS_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .flush(f_flush),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );
endmodule : microcode_store_access

// file: verif/microcode_store_access_chk.sv
/*
  Port checker for the microcode store access block.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module microcode_store_access_chk #(
  parameter int FIFO_DEPTH = 16,
  parameter int WR_WORDS = 2048
) (
  input wire logic sys_clk, // clock
  input wire logic reset_n, // reset
  input wire logic instr_valid, // offer
  input wire logic instr_ready, // take
  input wire logic [7:0] instr_op, // opcode
  input wire logic [3:0] instr_r1, // field
  input wire logic [31:0] instr_addr2, // operand
  input wire logic prot_mode, // protect
  input wire logic [31:0] gr_r2, // value
  input wire logic [31:0] gr1, // count
  input wire logic [31:0] loc_cur, // counter
  input wire logic [31:0] loc_next, // counter
  input wire logic priv_fault, // fault
  input wire logic useq_jump, // jump
  input wire logic [11:0] useq_target, // target
  input wire logic [31:0] useq_loc_cur, // counter
  input wire logic [31:0] useq_loc_next, // counter
  input wire logic cc_from_ucode, // cc
  input wire logic mem_req, // request
  input wire logic mem_we, // write
  input wire logic [19:0] mem_addr, // address
  input wire logic [31:0] mem_wdata, // data
  input wire logic mem_ack, // ack
  input wire logic cnt_wr_valid, // count write
  input wire logic [31:0] cnt_wr_data, // count
  input wire logic xfer_done, // done
  input wire logic loc_advance, // advance
  input wire logic ucode_rd_en, // fetch
  input wire logic [11:0] ucode_addr, // fetch addr
  input wire logic [10:0] rom_addr, // rom addr
  input wire logic [31:0] rom_data, // rom word
  input wire logic [31:0] ucode_data // fetched
);
  // decode of the taken instruction
  wire take = instr_valid && instr_ready;
  wire is_br = instr_op == 8'he5;
  wire is_ent = instr_op == 8'he9;
  wire is_load = instr_op == 8'he8 && instr_r1 == 4'h0;
  wire is_priv = is_br || (instr_op == 8'he8 && (instr_r1 == 4'h0 || instr_r1 == 4'h2));

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_branch_target: assert property (take && is_br && !prot_mode |=>
    useq_jump && useq_target == $past(instr_addr2[11:0])) else $error("branch target wrong");
  chk_entry_target: assert property (take && is_ent |=>
    useq_jump && useq_target == 12'h800 + {8'h00, $past(instr_r1)}) else $error("entry target");
  chk_loc_pair: assert property (take && (is_ent || (is_br && !prot_mode)) |=>
    useq_loc_cur == $past(loc_cur) && useq_loc_next == $past(loc_next)) else $error("loc pair");
  chk_priv_refuse: assert property (take && is_priv && prot_mode |=>
    priv_fault && !useq_jump && !mem_req) else $error("privileged op not refused");
  chk_cc_jump: assert property (cc_from_ucode == useq_jump)
    else $error("cc hand-over without jump");
  chk_load_first: assert property (take && is_load && !prot_mode |-> ##2
    mem_req && !mem_we && mem_addr == $past(gr_r2[19:0] + {gr1[17:0], 2'b00}, 2))
    else $error("first load fetch wrong");
  chk_mem_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request not held");
  chk_req_drop: assert property (mem_req && mem_ack |=> !mem_req) else $error("req after ack");
  chk_done_end: assert property (cnt_wr_valid && cnt_wr_data == 32'hffffffff |->
    ##[1:3] (xfer_done && loc_advance)) else $error("no completion after last word");
  chk_rom_fetch: assert property (ucode_rd_en && !ucode_addr[11] |->
    rom_addr == ucode_addr[10:0] ##1 ucode_data == $past(rom_data)) else $error("rom fetch");
endmodule : microcode_store_access_chk

bind microcode_store_access microcode_store_access_chk #(
  .FIFO_DEPTH(FIFO_DEPTH),
  .WR_WORDS(WR_WORDS)
) chk (.*);

// file: verif/mem_model.sv
/*
  Main memory model answering one request at a time.
  Assumes requests held until the one-cycle ack.
*/
`timescale 1ns/1ps
module mem_model (
  input wire logic sys_clk, // clock
  input wire logic reset_n, // reset
  input wire logic slow, // long latency
  input wire logic mem_req, // request
  input wire logic mem_we, // write
  input wire logic [19:0] mem_addr, // address
  input wire logic [31:0] mem_wdata, // data
  output logic mem_ack, // ack pulse
  output logic [31:0] mem_rdata // read data
);
  logic [31:0] ram [256];
  logic [2:0] wait_q;

  // fill words tagged by their index
  initial begin
    for (int i = 0; i < 256; i++) begin
      ram[i] = 32'hc0de0000 | i;
    end
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    wait_q = 3'h0;
  end

  // word aligned access, index drops low bits
  // read data holds through the cycle after the ack cycle, then inverts every cycle so stale data does not linger
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    if (!reset_n) begin
      wait_q <= 3'h0;
    end else if (mem_req && !mem_ack) begin
      if (wait_q >= (slow ? 3'h4 : 3'h0)) begin
        mem_ack <= 1'b1;
        wait_q <= 3'h0;
        if (mem_we) ram[mem_addr[9:2]] <= mem_wdata;
        else mem_rdata <= ram[mem_addr[9:2]];
      end else begin
        wait_q <= wait_q + 3'h1;
        mem_rdata <= ~mem_rdata;
      end
    end else if (!mem_ack) begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : mem_model

// file: verif/microcode_store_access_bench.sv
/*
  Self-checking bench: jumps, refusals, load, read, interrupt and resume.
  Assumes the memory model and the bound checker.
*/
`timescale 1ns/1ps
module microcode_store_access_bench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0, instr_ready, prot_mode = 1'b0, irq_pending = 1'b0, slow = 1'b0;
  logic [7:0] instr_op = 8'h00;
  logic [3:0] instr_r1 = 4'h0;
  logic [31:0] instr_addr2 = 32'h0, gr_r2 = 32'h0, gr0 = 32'h0, gr1 = 32'h0, gr2 = 32'h0;
  logic [31:0] gr3 = 32'h0, loc_cur = 32'h0, loc_next = 32'h0;
  logic priv_fault, cnt_wr_valid, xfer_done, loc_advance, useq_jump, cc_from_ucode;
  logic [1:0] cnt_wr_idx;
  logic [31:0] cnt_wr_data, useq_loc_cur, useq_loc_next, mem_wdata, mem_rdata, ucode_data;
  logic [11:0] useq_target;
  logic mem_req, mem_we, mem_ack, ucode_rd_en = 1'b0;
  logic [19:0] mem_addr;
  logic [11:0] ucode_addr = 12'h0;
  logic [10:0] rom_addr;
  wire [31:0] rom_data = {21'h0a5a5a, rom_addr};
  int miscompares = 0, comparisons = 0, cycles = 0;
  logic [31:0] left;
  logic adv;

  always #4 sys_clk = ~sys_clk;

  microcode_store_access DUT (.*);

  mem_model mem (.*);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // hang guard, the whole run needs a few hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  // offer one instruction, hold it until the take edge
  task automatic issue(input logic [7:0] op, input logic [3:0] r1, input logic [31:0] a2);
    @(posedge sys_clk);
    instr_op <= op;
    instr_r1 <= r1;
    instr_addr2 <= a2;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    while (instr_ready !== 1'b1) @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
  endtask : issue

  task automatic fetch(input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    ucode_rd_en <= 1'b1;
    ucode_addr <= a;
    @(posedge sys_clk);
    ucode_rd_en <= 1'b0;
    #1;
    check(ucode_data, exp, "microword");
  endtask : fetch

  // names neither the base nor the count register
  task automatic run_xfer(input logic [3:0] sub, input logic [31:0] r2, input logic [31:0] base,
      input logic [31:0] cnt, input int irq_at, output logic [31:0] last, output logic fin);
    logic [31:0] exp_cnt;
    int n;
    logic done;
    exp_cnt = cnt;
    n = 0;
    done = 1'b0;
    last = cnt;
    fin = 1'b0;
    @(posedge sys_clk);
    gr_r2 <= r2;
    gr0 <= base;
    gr2 <= base;
    gr1 <= cnt;
    gr3 <= cnt;
    issue(8'he8, sub, 32'h0);
    for (int k = 0; k < 3000 && !done; k++) begin
      @(posedge sys_clk);
      irq_pending <= (irq_at > 0 && n >= irq_at);
      #1;
      check(cc_from_ucode, 1'b0, "cc touched");
      if (cnt_wr_valid === 1'b1) begin
        exp_cnt = exp_cnt - 32'h1;
        n++;
        check(cnt_wr_data, exp_cnt, "count");
        check(cnt_wr_idx, (sub == 4'h0) ? 2'h1 : 2'h3, "count reg");
        last = cnt_wr_data;
      end
      if (xfer_done === 1'b1) begin
        done = 1'b1;
        fin = loc_advance;
      end
    end
    check(done, 1'b1, "no done");
    @(posedge sys_clk);
    irq_pending <= 1'b0;
  endtask : run_xfer

  // entries 0..15 and branches to both halves of the store
  task automatic t_jumps;
    logic [11:0] tg [4] = '{12'habc, 12'h7ff, 12'h000, 12'hfff};
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      loc_cur <= 32'h1000 + i;
      loc_next <= 32'h1004 + i;
      if (i < 16) issue(8'he9, i[3:0], ~i);
      else issue(8'he5, 4'(i), {20'hfa5a5, tg[i - 16]});
      check(useq_jump, 1'b1, "jump");
      check(cc_from_ucode, 1'b1, "cc");
      check(useq_target, (i < 16) ? 12'h800 + i : tg[i - 16], "target");
      check(useq_loc_cur, 32'h1000 + i, "loc cur");
      check(useq_loc_next, 32'h1004 + i, "loc next");
    end
  endtask : t_jumps

  // protect mode refuses load, read and branch but not entry
  task automatic t_priv;
    logic [7:0] ops [4] = '{8'he8, 8'he8, 8'he5, 8'he9};
    logic [3:0] r1s [4] = '{4'h0, 4'h2, 4'h0, 4'h3};
    @(posedge sys_clk);
    prot_mode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      issue(ops[i], r1s[i], 32'h0000_0900);
      check(priv_fault, i < 3, "fault");
      check(useq_jump, i == 3, "jump");
    end
    @(posedge sys_clk);
    prot_mode <= 1'b0;
  endtask : t_priv

  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_jumps();
    t_priv();
    // four words in, each to base plus count
    run_xfer(4'h0, 32'h40, 32'h810, 32'h3, 0, left, adv);
    check(adv, 1'b1, "advance");
    for (int c = 0; c < 4; c++) fetch(12'h810 + c, 32'hc0de0010 + c);
    fetch(12'h123, {21'h0a5a5a, 11'h123});
    // copy back to memory with a slow memory
    slow <= 1'b1;
    run_xfer(4'h2, 32'h200, 32'h810, 32'h3, 0, left, adv);
    check(adv, 1'b1, "advance");
    for (int c = 0; c < 4; c++) check(mem.ram[128 + c], 32'hc0de0010 + c, "copy");
    slow <= 1'b0;
    // interrupted load, then resumed from the written count
    run_xfer(4'h0, 32'h80, 32'h820, 32'h7, 2, left, adv);
    check(adv, 1'b0, "advance on irq");
    check(left === 32'hffffffff, 1'b0, "stopped early");
    run_xfer(4'h0, 32'h80, 32'h820, left, 0, left, adv);
    check(adv, 1'b1, "resume");
    for (int c = 0; c < 8; c++) fetch(12'h820 + c, 32'hc0de0020 + c);
    final_report();
  end
endmodule : microcode_store_access_bench
